/* inc/spg_pkg.sv */
// Constants and carrier types for the serializer housekeeping block.
// Assumes a 200 MHz reference clock and an 8-bit register space.
package spg_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] REMOTE_POWER_DOWN_CONTROL_ADDR = 8'h01;
  localparam logic [7:0] LINK_DETECT_STATUS_ADDR = 8'h0C;
  localparam logic [7:0] GPIO0_MODE_CONFIG_ADDR = 8'h0D;
  localparam logic [7:0] GPIO1_GPIO2_MODE_CONFIG_ADDR = 8'h0E;
  localparam logic [7:0] GPIO3_GPIO5_MODE_CONFIG_ADDR = 8'h0F;
  localparam logic [7:0] GPIO6_GPIO7_MODE_CONFIG_ADDR = 8'h10;
  localparam logic [7:0] GPIO8_MODE_CONFIG_ADDR = 8'h11;
  localparam logic [7:0] VIDEO_WIDTH_MODE_CONFIG_ADDR = 8'h12;
  localparam logic [7:0] GPIO_INPUT_LEVELS_ADDR = 8'h1C;
  localparam logic [7:0] GPIO8_INPUT_LEVEL_ADDR = 8'h1D;
  localparam logic [7:0] INTERRUPT_ARM_CONTROL_ADDR = 8'hC6;
  localparam logic [7:0] IRQ_SOURCE_ADDR = 8'hC7;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int REMOTE_APD_EN_BIT = 7;
  localparam int CLK_LOSS_SLEEP_EN_BIT = 1;
  localparam int LINK_DETECT_BIT = 0;
  localparam int PCLK_PRESENT_BIT = 1;
  localparam int VIDEO18_BIT = 2;
  localparam int LOW_FREQ_BIT = 1;
  localparam int LEGACY_BIT = 0;
  localparam int IRQ_ARM_BIT = 0;
  localparam int IRQ_CFG_BIT = 5;
  localparam int IRQ_REMOTE_BIT = 0;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] REMOTE_POWER_DOWN_CONTROL_RST = 8'h00;
  localparam logic [7:0] GPIO_MODE_CONFIG_RST = 8'h00;
  localparam logic [7:0] VIDEO_WIDTH_MODE_CONFIG_RST = 8'h00;
  localparam logic [7:0] INTERRUPT_ARM_CONTROL_RST = 8'h00;

  // ****************************************************************
  // GPIO nibble codes
  // ****************************************************************
  localparam logic [3:0] GPIO_OUT_LOW = 4'h1;
  localparam logic [3:0] GPIO_INPUT = 4'h3;
  localparam logic [3:0] GPIO_BACK_OUT = 4'h5;
  localparam logic [3:0] GPIO_OUT_HIGH = 4'h9;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int REF_CLK_PERIOD_PS = 5000;
  localparam int LOSS_FREQ_KHZ = 1000;
  localparam int LOSS_WINDOW_NS = 4000;
  localparam int LOSS_WINDOW_CYCLES = (LOSS_WINDOW_NS * 1000) / REF_CLK_PERIOD_PS;
  localparam int LOSS_EDGE_THRESH = (LOSS_FREQ_KHZ * LOSS_WINDOW_NS) / 1000000;
  localparam int LINE_RATE_LF_MULT = 4;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } spg_reg_req_type;

  typedef enum logic [1:0] {
    APD_ACTIVE = 2'b00,
    APD_SLEEP = 2'b01,
    APD_RESUME = 2'b10
  } spg_apd_state_type;

endpackage

/* logic/spg_clk_presence.sv */
// Input pixel clock presence detector.
// Assumes the monitored clock is sampled as an ordinary synchronous input.
`timescale 1ns/1ps
module spg_clk_presence
  import spg_pkg::*;
#(
  parameter int WINDOW_CYCLES = LOSS_WINDOW_CYCLES,
  parameter int EDGE_THRESH = LOSS_EDGE_THRESH,
  parameter int CNT_W = 16
) (
  input wire logic ref_clk_in, // Free-running timebase
  input wire logic sys_rst_in, // Synchronous reset
  input wire logic mon_clk_in, // Monitored clock level
  output logic present_out // Clock seen at or above threshold
);

  logic prev_reg;
  logic prev_next;
  logic [CNT_W-1:0] win_reg;
  logic [CNT_W-1:0] win_next;
  logic [CNT_W-1:0] edge_reg;
  logic [CNT_W-1:0] edge_next;
  logic present_reg;
  logic present_next;

  // ****************************************************************
  // Edge counting over a fixed window
  // ****************************************************************
  always_comb begin
    prev_next = mon_clk_in;
    present_next = present_reg;
    win_next = win_reg + CNT_W'(1);
    edge_next = edge_reg;
    if (mon_clk_in && !prev_reg && (edge_reg != {CNT_W{1'b1}})) begin
      edge_next = edge_reg + CNT_W'(1);
    end
    if (win_reg == CNT_W'(WINDOW_CYCLES - 1)) begin
      present_next = (edge_reg >= CNT_W'(EDGE_THRESH));
      win_next = '0;
      edge_next = '0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      prev_reg <= 1'b1;
      win_reg <= '0;
      edge_reg <= '0;
      present_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
      win_reg <= win_next;
      edge_reg <= edge_next;
      present_reg <= present_next;
    end
  end

  assign present_out = present_reg;

endmodule

/* logic/spg_serializer_ctrl.sv */
// Serializer housekeeping: remote auto power-down, clock-loss sleep,
// link fault status, low-frequency mode, interrupt forwarding and GPIO.
// Assumes a register port fed by the local I2C slave or control channel,
// and a reset derived from the power-down pin.
`timescale 1ns/1ps

// Notes on behaviour
// - 0x01 bit 7 enables remote auto power-down
// - No back channel while enabled: reduced power
// - Resume on back channel; transmit after bit cleared
// - Optional sleep when pixel clock below 1MHz
// - Relock on clock return; registers kept
// - Fault shows as zero in link_detect_status bit 0
// - One combined indication for all cable faults
// - Low-frequency mode by pin or register
// - Low-frequency mode quadruples line rate ratio; ratio stays 1 in legacy mode
// - Armed (0xC6 bits 0 and 5) and remote interrupt low pulls output; never in legacy mode
// - Reading source register clears and rearms interrupt
// - Four link GPIOs, forward input or back output; no link transfer in legacy mode
// - 0x12 bit 2 selects and loads 18-bit mode
// - Link GPIO modes set by nibble, 3 or 5
// - Local codes 1 low, 9 high, 3 input
// - Register GPIO mode overrides shared audio input
// - Register GPIOs never carried across link
// - Link GPIO levels readable, local output allowed
// - Power-down reset returns registers to defaults
module spg_serializer_ctrl
  import spg_pkg::*;
#(
  parameter int LOSS_WIN_CYCLES = LOSS_WINDOW_CYCLES,
  parameter int LOSS_THRESH = LOSS_EDGE_THRESH
) (
  input wire logic ref_clk_in, // 200 MHz clock
  input wire logic sys_rst_in, // Sync reset from power-down pin
  input wire spg_reg_req_type reg_req_in, // Register access request
  input wire logic back_channel_det_in, // Back channel detected
  input wire logic lvds_clk_in, // Pixel clock level
  input wire logic link_fault_in, // Combined cable fault
  input wire logic low_freq_select_in, // Low-frequency mode pin
  input wire logic legacy_compat_select_in, // Backward compatible pin
  input wire logic remote_irq_n_in, // Remote interrupt, low active
  input wire logic [7:0] gpio_pin_in, // Pin levels GPIO0-3,5-8
  input wire logic [3:0] bc_gpio_in, // Back channel GPIO values
  output logic [7:0] reg_rdata_out, // Read data
  output logic reg_rvalid_out, // Read data valid pulse
  output logic power_save_out, // Reduced-power state
  output logic fwd_tx_en_out, // Forward channel transmit enable
  output logic clk_sleep_out, // Clock-loss sleep state
  output logic relock_out, // Relock request pulse
  output logic [2:0] line_rate_mult_out, // Line rate ratio multiplier
  output logic legacy_mode_out, // Backward compatible mode
  output logic video18_load_out, // 18-bit mode for remote load
  output logic irq_out_n_out, // Interrupt pin drive value
  output logic irq_oe_n_out, // Interrupt pin enable, low drives
  output logic [7:0] gpio_pin_out, // Pin drive values
  output logic [7:0] gpio_oe_n_out, // Pin enables, low drives
  output logic [3:0] fwd_gpio_out, // Forward channel GPIO values
  output logic [7:0] audio_data_out // Audio inputs from shared pins
);

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [7:0] rpd_ctrl_reg;
  logic [7:0] rpd_ctrl_next;
  logic [7:0] gpio0_cfg_reg;
  logic [7:0] gpio0_cfg_next;
  logic [7:0] gpio12_cfg_reg;
  logic [7:0] gpio12_cfg_next;
  logic [7:0] gpio35_cfg_reg;
  logic [7:0] gpio35_cfg_next;
  logic [7:0] gpio67_cfg_reg;
  logic [7:0] gpio67_cfg_next;
  logic [7:0] gpio8_cfg_reg;
  logic [7:0] gpio8_cfg_next;
  logic [7:0] vid_cfg_reg;
  logic [7:0] vid_cfg_next;
  logic [7:0] irq_arm_reg;
  logic [7:0] irq_arm_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic src_read;
  logic [7:0] pin_reg;
  logic link_ok_reg;
  logic pclk_ok;
  logic irq_pend_reg;

  always_comb begin
    rpd_ctrl_next = rpd_ctrl_reg;
    gpio0_cfg_next = gpio0_cfg_reg;
    gpio12_cfg_next = gpio12_cfg_reg;
    gpio35_cfg_next = gpio35_cfg_reg;
    gpio67_cfg_next = gpio67_cfg_reg;
    gpio8_cfg_next = gpio8_cfg_reg;
    vid_cfg_next = vid_cfg_reg;
    irq_arm_next = irq_arm_reg;
    rdata_next = rdata_reg;
    rvalid_next = reg_req_in.rd;
    src_read = 1'b0;
    if (reg_req_in.wr) begin
      unique case (reg_req_in.addr)
        REMOTE_POWER_DOWN_CONTROL_ADDR: rpd_ctrl_next = reg_req_in.wdata;
        GPIO0_MODE_CONFIG_ADDR: gpio0_cfg_next = reg_req_in.wdata;
        GPIO1_GPIO2_MODE_CONFIG_ADDR: gpio12_cfg_next = reg_req_in.wdata;
        GPIO3_GPIO5_MODE_CONFIG_ADDR: gpio35_cfg_next = reg_req_in.wdata;
        GPIO6_GPIO7_MODE_CONFIG_ADDR: gpio67_cfg_next = reg_req_in.wdata;
        GPIO8_MODE_CONFIG_ADDR: gpio8_cfg_next = reg_req_in.wdata;
        VIDEO_WIDTH_MODE_CONFIG_ADDR: vid_cfg_next = reg_req_in.wdata;
        INTERRUPT_ARM_CONTROL_ADDR: irq_arm_next = reg_req_in.wdata;
        default: ;
      endcase
    end
    if (reg_req_in.rd) begin
      unique case (reg_req_in.addr)
        REMOTE_POWER_DOWN_CONTROL_ADDR: rdata_next = rpd_ctrl_reg;
        LINK_DETECT_STATUS_ADDR: begin
          rdata_next = 8'h00;
          rdata_next[LINK_DETECT_BIT] = link_ok_reg;
          rdata_next[PCLK_PRESENT_BIT] = pclk_ok;
        end
        GPIO0_MODE_CONFIG_ADDR: rdata_next = gpio0_cfg_reg;
        GPIO1_GPIO2_MODE_CONFIG_ADDR: rdata_next = gpio12_cfg_reg;
        GPIO3_GPIO5_MODE_CONFIG_ADDR: rdata_next = gpio35_cfg_reg;
        GPIO6_GPIO7_MODE_CONFIG_ADDR: rdata_next = gpio67_cfg_reg;
        GPIO8_MODE_CONFIG_ADDR: rdata_next = gpio8_cfg_reg;
        VIDEO_WIDTH_MODE_CONFIG_ADDR: rdata_next = vid_cfg_reg;
        GPIO_INPUT_LEVELS_ADDR: rdata_next = {pin_reg[6:4], 1'b0, pin_reg[3:0]};
        GPIO8_INPUT_LEVEL_ADDR: rdata_next = {7'h00, pin_reg[7]};
        INTERRUPT_ARM_CONTROL_ADDR: rdata_next = irq_arm_reg;
        IRQ_SOURCE_ADDR: begin
          rdata_next = 8'h00;
          rdata_next[IRQ_REMOTE_BIT] = irq_pend_reg;
          src_read = 1'b1;
        end
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // Settings survive clock loss; only the power-down reset clears them
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      rpd_ctrl_reg <= REMOTE_POWER_DOWN_CONTROL_RST;
      gpio0_cfg_reg <= GPIO_MODE_CONFIG_RST;
      gpio12_cfg_reg <= GPIO_MODE_CONFIG_RST;
      gpio35_cfg_reg <= GPIO_MODE_CONFIG_RST;
      gpio67_cfg_reg <= GPIO_MODE_CONFIG_RST;
      gpio8_cfg_reg <= GPIO_MODE_CONFIG_RST;
      vid_cfg_reg <= VIDEO_WIDTH_MODE_CONFIG_RST;
      irq_arm_reg <= INTERRUPT_ARM_CONTROL_RST;
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rpd_ctrl_reg <= rpd_ctrl_next;
      gpio0_cfg_reg <= gpio0_cfg_next;
      gpio12_cfg_reg <= gpio12_cfg_next;
      gpio35_cfg_reg <= gpio35_cfg_next;
      gpio67_cfg_reg <= gpio67_cfg_next;
      gpio8_cfg_reg <= gpio8_cfg_next;
      vid_cfg_reg <= vid_cfg_next;
      irq_arm_reg <= irq_arm_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // ****************************************************************
  // Mode straps, captured one cycle after reset release
  // ****************************************************************
  logic strap_done_reg;
  logic strap_done_next;
  logic lf_strap_reg;
  logic lf_strap_next;
  logic bk_strap_reg;
  logic bk_strap_next;
  logic lf_mode;
  logic legacy;

  always_comb begin
    strap_done_next = 1'b1;
    lf_strap_next = lf_strap_reg;
    bk_strap_next = bk_strap_reg;
    if (!strap_done_reg) begin
      lf_strap_next = low_freq_select_in;
      bk_strap_next = legacy_compat_select_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      strap_done_reg <= 1'b0;
      lf_strap_reg <= 1'b0;
      bk_strap_reg <= 1'b0;
    end else begin
      strap_done_reg <= strap_done_next;
      lf_strap_reg <= lf_strap_next;
      bk_strap_reg <= bk_strap_next;
    end
  end

  assign lf_mode = lf_strap_reg | vid_cfg_reg[LOW_FREQ_BIT];
  assign legacy = bk_strap_reg | vid_cfg_reg[LEGACY_BIT];

  // ****************************************************************
  // Remote auto power-down
  // ****************************************************************
  spg_apd_state_type apd_state_reg;
  spg_apd_state_type apd_state_next;
  logic apd_en;

  assign apd_en = rpd_ctrl_reg[REMOTE_APD_EN_BIT];

  always_comb begin
    apd_state_next = apd_state_reg;
    unique case (apd_state_reg)
      APD_ACTIVE: begin
        if (apd_en && !back_channel_det_in) begin
          apd_state_next = APD_SLEEP;
        end
      end
      APD_SLEEP: begin
        if (!apd_en) begin
          apd_state_next = APD_ACTIVE;
        end else if (back_channel_det_in) begin
          apd_state_next = APD_RESUME;
        end
      end
      APD_RESUME: begin
        if (!apd_en) begin
          apd_state_next = APD_ACTIVE;
        end else if (!back_channel_det_in) begin
          apd_state_next = APD_SLEEP;
        end
      end
      default: apd_state_next = APD_ACTIVE;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      apd_state_reg <= APD_ACTIVE;
    end else begin
      apd_state_reg <= apd_state_next;
    end
  end

  // ****************************************************************
  // Pixel clock loss detect
  // ****************************************************************
  spg_clk_presence #(
    .WINDOW_CYCLES(LOSS_WIN_CYCLES),
    .EDGE_THRESH(LOSS_THRESH),
    .CNT_W(16)
  ) u_clk_presence (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .mon_clk_in(lvds_clk_in),
    .present_out(pclk_ok)
  );

  // ****************************************************************
  // Interrupt forwarding, held until source read
  // ****************************************************************
  logic irq_pend_next;
  logic irq_set;

  always_comb begin
    irq_set = irq_arm_reg[IRQ_ARM_BIT] && irq_arm_reg[IRQ_CFG_BIT] && !legacy && !remote_irq_n_in;
    irq_pend_next = irq_set || (irq_pend_reg && !src_read);
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      irq_pend_reg <= 1'b0;
    end else begin
      irq_pend_reg <= irq_pend_next;
    end
  end

  // ****************************************************************
  // GPIO pins, link forwarding and audio sharing
  // ****************************************************************
  logic [3:0] nib [8];
  logic [7:0] pin_out_next;
  logic [7:0] pin_oe_n_next;
  logic [3:0] fwd_next;
  logic [7:0] audio_next;

  assign nib[0] = gpio0_cfg_reg[3:0];
  assign nib[1] = gpio12_cfg_reg[3:0];
  assign nib[2] = gpio12_cfg_reg[7:4];
  assign nib[3] = gpio35_cfg_reg[3:0];
  assign nib[4] = gpio35_cfg_reg[7:4];
  assign nib[5] = gpio67_cfg_reg[3:0];
  assign nib[6] = gpio67_cfg_reg[7:4];
  assign nib[7] = gpio8_cfg_reg[3:0];

  always_comb begin
    pin_out_next = 8'h00;
    pin_oe_n_next = 8'hFF;
    fwd_next = 4'h0;
    audio_next = gpio_pin_in;
    for (int i = 0; i < 8; i++) begin
      unique case (nib[i])
        GPIO_OUT_LOW: begin
          pin_oe_n_next[i] = 1'b0;
          audio_next[i] = 1'b0;
        end
        GPIO_OUT_HIGH: begin
          pin_out_next[i] = 1'b1;
          pin_oe_n_next[i] = 1'b0;
          audio_next[i] = 1'b0;
        end
        GPIO_INPUT: begin
          audio_next[i] = 1'b0;
          if (i < 4 && !legacy) begin
            fwd_next[i] = gpio_pin_in[i];
          end
        end
        GPIO_BACK_OUT: begin
          if (i < 4 && !legacy) begin
            pin_out_next[i] = bc_gpio_in[i];
            pin_oe_n_next[i] = 1'b0;
            audio_next[i] = 1'b0;
          end
        end
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Output registers
  // ****************************************************************
  logic pclk_ok_reg;
  logic clk_sleep_next;
  logic [2:0] mult_next;

  always_comb begin
    clk_sleep_next = rpd_ctrl_reg[CLK_LOSS_SLEEP_EN_BIT] && !pclk_ok;
    mult_next = (lf_mode && !legacy) ? 3'(LINE_RATE_LF_MULT) : 3'h1;
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      pin_reg <= 8'h00;
      link_ok_reg <= 1'b0;
      pclk_ok_reg <= 1'b0;
      power_save_out <= 1'b0;
      fwd_tx_en_out <= 1'b0;
      clk_sleep_out <= 1'b0;
      relock_out <= 1'b0;
      line_rate_mult_out <= 3'h1;
      legacy_mode_out <= 1'b0;
      video18_load_out <= 1'b0;
      irq_out_n_out <= 1'b1;
      irq_oe_n_out <= 1'b1;
      gpio_pin_out <= 8'h00;
      gpio_oe_n_out <= 8'hFF;
      fwd_gpio_out <= 4'h0;
      audio_data_out <= 8'h00;
    end else begin
      pin_reg <= gpio_pin_in;
      link_ok_reg <= !link_fault_in;
      pclk_ok_reg <= pclk_ok;
      power_save_out <= (apd_state_next == APD_SLEEP);
      fwd_tx_en_out <= (apd_state_next == APD_ACTIVE);
      clk_sleep_out <= clk_sleep_next;
      relock_out <= pclk_ok && !pclk_ok_reg;
      line_rate_mult_out <= mult_next;
      legacy_mode_out <= legacy;
      video18_load_out <= vid_cfg_reg[VIDEO18_BIT];
      irq_out_n_out <= !irq_pend_next;
      irq_oe_n_out <= !irq_pend_next;
      gpio_pin_out <= pin_out_next;
      gpio_oe_n_out <= pin_oe_n_next;
      fwd_gpio_out <= fwd_next;
      audio_data_out <= audio_next;
    end
  end

  assign reg_rdata_out = rdata_reg;
  assign reg_rvalid_out = rvalid_reg;

endmodule

/* tb/spg_ctrl_asserts.sv */
// Port checker for the serializer housekeeping block.
// Assumes a bind onto spg_serializer_ctrl, one clock domain.
`timescale 1ns/1ps
module spg_ctrl_asserts
  import spg_pkg::*;
(
  input wire logic ref_clk_in, // Clock
  input wire logic sys_rst_in, // Sync reset
  input wire spg_reg_req_type reg_req_in, // Register request
  input wire logic link_fault_in, // Cable fault
  input wire logic [7:0] reg_rdata_out, // Read data
  input wire logic reg_rvalid_out, // Read valid
  input wire logic power_save_out, // Reduced power
  input wire logic fwd_tx_en_out, // Transmit enable
  input wire logic relock_out, // Relock pulse
  input wire logic [2:0] line_rate_mult_out, // Ratio
  input wire logic legacy_mode_out, // Legacy mode
  input wire logic irq_out_n_out, // Interrupt value
  input wire logic irq_oe_n_out // Interrupt enable
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (sys_rst_in);
  sequence s_src_read;
    reg_req_in.rd && reg_req_in.addr == IRQ_SOURCE_ADDR;
  endsequence
  sequence s_stat_read;
    reg_req_in.rd && reg_req_in.addr == LINK_DETECT_STATUS_ADDR && $stable(link_fault_in);
  endsequence
  a_rd_answer: assert property (reg_req_in.rd |=> reg_rvalid_out)
    else $error("read not answered");
  a_no_stray_valid: assert property (!reg_req_in.rd |=> !reg_rvalid_out)
    else $error("valid without read");
  a_fault_status: assert property (s_stat_read |=> reg_rdata_out[0] == !$past(link_fault_in))
    else $error("link detect bit wrong");
  a_sleep_no_tx: assert property (power_save_out |-> !fwd_tx_en_out)
    else $error("transmit during power save");
  a_irq_held: assert property (!irq_out_n_out && !(reg_req_in.rd && reg_req_in.addr == IRQ_SOURCE_ADDR)
    |=> !irq_out_n_out)
    else $error("interrupt dropped before read");
  a_src_report: assert property (s_src_read |=> reg_rdata_out[0] == !$past(irq_out_n_out))
    else $error("source bit wrong");
  a_open_drain: assert property (irq_oe_n_out == irq_out_n_out)
    else $error("interrupt pin drives high");
  a_legacy_ratio: assert property (legacy_mode_out |-> line_rate_mult_out == 3'h1)
    else $error("ratio changed in legacy mode");
  a_ratio_legal: assert property (line_rate_mult_out == 3'h1 || line_rate_mult_out == 3'h4)
    else $error("illegal ratio");
  a_relock_pulse: assert property (relock_out |=> !relock_out)
    else $error("relock not a pulse");
endmodule

/* tb/spg_far_model.sv */
// Far-side model: deserializer back channel, remote interrupt, pixel clock.
// Assumes commands from the bench; clock stands still when stopped.
`timescale 1ns/1ps
module spg_far_model (
  input wire logic ref_clk_in, // Timebase
  input wire logic bc_on_in, // Deserializer powered
  input wire logic irq_req_in, // Raise remote interrupt
  input wire logic clk_run_in, // Pixel clock running
  output logic back_channel_det_out, // Back channel present
  output logic remote_irq_n_out, // Remote interrupt, low active
  output logic lvds_clk_out // Pixel clock
);
  logic [1:0] div_reg = 2'h0;
  always @(posedge ref_clk_in) begin
    div_reg <= clk_run_in ? div_reg + 2'h1 : div_reg;
  end
  assign lvds_clk_out = div_reg[1];
  assign back_channel_det_out = bc_on_in;
  assign remote_irq_n_out = !(bc_on_in && irq_req_in);
endmodule

/* tb/tb_top.sv */
// Self-checking bench for spg_serializer_ctrl.
// Assumes spg_far_model and spg_ctrl_asserts compiled before it.
`timescale 1ns/1ps
module tb_top;
  import spg_pkg::*;
  logic ref_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  spg_reg_req_type req = '0;
  logic fault = 1'b0, lf_pin = 1'b0, bc_on = 1'b0, irq_req = 1'b0, clk_run = 1'b1;
  logic bc_det, rirq_n, lvds_clk, rvalid, psave, txen, csleep, relock, legacy, v18, irq_n, irq_oe_n;
  logic [7:0] pin_in = 8'h00, rdata, gp_out, gp_oe_n, audio, v;
  logic [3:0] bc_gpio = 4'h0, fwd, c;
  logic [2:0] mult;
  logic [7:0] cfg_a [7] = '{8'h01, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12};
  logic [3:0] codes [5] = '{4'h0, 4'h1, 4'h3, 4'h5, 4'h9};
  int err_total = 0;
  int total_checks = 0;
  always #2.5 ref_clk_in = ~ref_clk_in;
  spg_far_model far (.ref_clk_in(ref_clk_in), .bc_on_in(bc_on), .irq_req_in(irq_req), .clk_run_in(clk_run),
    .back_channel_det_out(bc_det), .remote_irq_n_out(rirq_n), .lvds_clk_out(lvds_clk));
  spg_serializer_ctrl #(.LOSS_WIN_CYCLES(20), .LOSS_THRESH(1)) DUT (.ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in), .reg_req_in(req), .back_channel_det_in(bc_det), .lvds_clk_in(lvds_clk),
    .link_fault_in(fault), .low_freq_select_in(lf_pin), .legacy_compat_select_in(1'b0),
    .remote_irq_n_in(rirq_n), .gpio_pin_in(pin_in), .bc_gpio_in(bc_gpio), .reg_rdata_out(rdata),
    .reg_rvalid_out(rvalid), .power_save_out(psave), .fwd_tx_en_out(txen), .clk_sleep_out(csleep),
    .relock_out(relock), .line_rate_mult_out(mult), .legacy_mode_out(legacy), .video18_load_out(v18),
    .irq_out_n_out(irq_n), .irq_oe_n_out(irq_oe_n), .gpio_pin_out(gp_out), .gpio_oe_n_out(gp_oe_n),
    .fwd_gpio_out(fwd), .audio_data_out(audio));
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [7:0] exp_oe(input logic [3:0] k);
    return (k == 4'h1 || k == 4'h9) ? 8'h00 : (k == 4'h5 ? 8'hF0 : 8'hFF);
  endfunction
  function automatic logic [7:0] exp_pin(input logic [3:0] k, input logic [3:0] b);
    return k == 4'h9 ? 8'hFF : (k == 4'h5 ? {4'h0, b} : 8'h00);
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_in);
    req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(negedge ref_clk_in);
    req.wr = 1'b0;
  endtask
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [7:0] e);
    @(negedge ref_clk_in);
    req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(negedge ref_clk_in);
    req.rd = 1'b0;
    chk("rvalid", 8'h01, {7'h0, rvalid});
    chk(n, e, rdata);
  endtask
  task automatic do_reset();
    sys_rst_in = 1'b1;
    wait_cyc(12);
    sys_rst_in = 1'b0;
    wait_cyc(2);
  endtask
  task automatic wrap_up();
    if (err_total == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    void'($urandom(19));
    do_reset();
    chk("txen_idle", 8'h01, {7'h0, txen});
    foreach (cfg_a[i]) rd_chk("reset_val", cfg_a[i], 8'h00);
    rd_chk("arm_reset", 8'hC6, 8'h00);
    foreach (codes[k]) begin
      c = codes[k];
      pin_in = 8'($urandom());
      bc_gpio = 4'($urandom());
      for (int i = 1; i < 6; i++) reg_wr(cfg_a[i], {c, c});
      wait_cyc(2);
      chk("gp_oe", exp_oe(c), gp_oe_n);
      chk("gp_out", exp_pin(c, bc_gpio), gp_out);
      if (c != 4'h5) chk("audio", c == 4'h0 ? pin_in : 8'h00, audio);
      if (c == 4'h3) begin
        chk("fwd", {4'h0, pin_in[3:0]}, {4'h0, fwd});
        rd_chk("lvl", 8'h1C, {pin_in[6:4], 1'b0, pin_in[3:0]});
        rd_chk("lvl8", 8'h1D, {7'h0, pin_in[7]});
      end
    end
    repeat (3) begin
      v = 8'($urandom());
      reg_wr(8'h10, v);
      rd_chk("cfg_rw", 8'h10, v);
    end
    rd_chk("unmapped", 8'h55, 8'h00);
    reg_wr(8'h0C, 8'hFF);
    reg_wr(8'h01, 8'h02);
    fault = 1'b1;
    wait_cyc(2);
    rd_chk("stat_fault", 8'h0C, 8'h02);
    fault = 1'b0;
    wait_cyc(2);
    rd_chk("stat_ok", 8'h0C, 8'h03);
    clk_run = 1'b0;
    wait_cyc(50);
    chk("clk_sleep", 8'h01, {7'h0, csleep});
    rd_chk("stat_loss", 8'h0C, 8'h01);
    clk_run = 1'b1;
    for (int i = 0; i < 60 && relock !== 1'b1; i++) @(negedge ref_clk_in);
    chk("relock", 8'h01, {7'h0, relock});
    wait_cyc(2);
    chk("clk_wake", 8'h00, {7'h0, csleep});
    rd_chk("kept", 8'h0D, 8'h99);
    reg_wr(8'h01, 8'h80);
    wait_cyc(2);
    chk("apd_sleep", 8'h10, {3'h0, psave, 3'h0, txen});
    bc_on = 1'b1;
    wait_cyc(2);
    chk("apd_resume", 8'h00, {3'h0, psave, 3'h0, txen});
    bc_on = 1'b0;
    wait_cyc(2);
    chk("apd_resleep", 8'h10, {3'h0, psave, 3'h0, txen});
    bc_on = 1'b1;
    wait_cyc(2);
    reg_wr(8'h01, 8'h00);
    wait_cyc(2);
    chk("apd_wake", 8'h01, {3'h0, psave, 3'h0, txen});
    reg_wr(8'hC6, 8'h01);
    irq_req = 1'b1;
    wait_cyc(3);
    chk("irq_unarmed", 8'h01, {7'h0, irq_n});
    irq_req = 1'b0;
    reg_wr(8'hC6, 8'h21);
    irq_req = 1'b1;
    wait_cyc(1);
    irq_req = 1'b0;
    wait_cyc(3);
    chk("irq_low", 8'h00, {3'h0, irq_n, 3'h0, irq_oe_n});
    rd_chk("irq_src", 8'hC7, 8'h01);
    chk("irq_clear", 8'h11, {3'h0, irq_n, 3'h0, irq_oe_n});
    reg_wr(8'h12, 8'h02);
    wait_cyc(2);
    chk("lf_reg", 8'h04, {4'h0, legacy, mult});
    reg_wr(8'h12, 8'h03);
    wait_cyc(2);
    chk("lf_legacy", 8'h09, {4'h0, legacy, mult});
    reg_wr(8'h12, 8'h04);
    wait_cyc(2);
    chk("v18", 8'h11, {3'h0, v18, 1'b0, mult});
    lf_pin = 1'b1;
    do_reset();
    chk("lf_pin", 8'h04, {4'h0, legacy, mult});
    rd_chk("rst_mode", 8'h12, 8'h00);
    rd_chk("rst_gpio", 8'h0D, 8'h00);
    wrap_up();
  end
  initial begin
    #100000;
    err_total++;
    wrap_up();
  end
endmodule
bind spg_serializer_ctrl spg_ctrl_asserts u_chk (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
  .reg_req_in(reg_req_in), .link_fault_in(link_fault_in), .reg_rdata_out(reg_rdata_out),
  .reg_rvalid_out(reg_rvalid_out), .power_save_out(power_save_out), .fwd_tx_en_out(fwd_tx_en_out),
  .relock_out(relock_out), .line_rate_mult_out(line_rate_mult_out), .legacy_mode_out(legacy_mode_out),
  .irq_out_n_out(irq_out_n_out), .irq_oe_n_out(irq_oe_n_out));
